// *** sfrc_top.sv ***
// status flags and reset-cause recording for an 8-bit core
// assumes execute stage gives one-cycle event pulses
module sfrc_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // execute stage
  input wire sfrc_pkg::sfrc_alu_s alu_i,
  input wire logic flags_we_i,
  input wire logic [7:0] flags_wdata_i,
  input wire logic cause_we_i,
  input wire logic [7:0] cause_wdata_i,
  input wire logic wdt_clear_i,
  input wire logic sleep_i,
  input wire logic [14:0] pc_i,
  input wire logic instr_done_i,
  input wire logic global_irq_enable_i,
  input wire logic stack_fault_reset_enable_i,
  // reset and wake sources
  input wire sfrc_pkg::sfrc_evt_s evt_i,
  input wire logic brownout_lvl_i,
  // outputs
  output logic [7:0] flags_o,
  output logic [7:0] cause_o,
  output logic [7:0] alu_res_o,
  output logic asleep_o,
  output logic [14:0] pc_load_o,
  output logic pc_load_vld_o,
  output logic irq_push_o
);
  import sfrc_pkg::*;

  sfrc_state_s st_r;
  sfrc_state_s st_nxt;
  logic [7:0] res;
  sfrc_aflag_s af;
  logic z_upd;
  logic c_upd;
  logic nov_upd;
  logic bo_lvl;
  logic bo_lvl_q_r;
  logic bo_evt;
  logic stk_ovf_rst;
  logic stk_unf_rst;
  logic asleep;
  logic add_cy;
  logic sub_nb;

  sfrc_alu_flags u_alu (
    .alu_i(alu_i),
    .carry_in_i(st_r.flags[C_POS]),
    .res_o(res),
    .flag_o(af),
    .z_upd_o(z_upd),
    .c_upd_o(c_upd),
    .nov_upd_o(nov_upd)
  );

  sfrc_sync u_bo_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .d_i(brownout_lvl_i),
    .q_o(bo_lvl)
  );

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bo_lvl_q_r <= 1'b0;
    end else begin
      bo_lvl_q_r <= bo_lvl;
    end
  end

  assign bo_evt = (bo_lvl & ~bo_lvl_q_r) | evt_i.brownout;
  assign stk_ovf_rst = evt_i.stk_ovf & stack_fault_reset_enable_i;
  assign stk_unf_rst = evt_i.stk_unf & stack_fault_reset_enable_i;
  assign asleep = (st_r.mode == SFRC_SLEEP);
  assign add_cy = (9'(alu_i.a) + 9'(alu_i.b)) > 9'h0FF;
  assign sub_nb = alu_i.a >= alu_i.b;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load_vld = 1'b0;
    st_nxt.alu_res = res;
    // writes reach only the arithmetic bits, and none of them under a flag-affecting op
    if (flags_we_i && !(z_upd || nov_upd || c_upd)) begin
      st_nxt.flags = (st_r.flags & ~FLAGS_WMASK) | (flags_wdata_i & FLAGS_WMASK);
    end
    if (cause_we_i) begin
      st_nxt.cause = cause_wdata_i & CAUSE_MASK;
    end
    // operation flags beat the written ones
    if (z_upd) begin
      st_nxt.flags[Z_POS] = af.z;
    end
    if (nov_upd) begin
      st_nxt.flags[NOV_POS] = af.nov;
    end
    if (c_upd) begin
      st_nxt.flags[C_POS] = af.c;
    end
    if (wdt_clear_i) begin
      st_nxt.flags[WE_POS] = 1'b1;
      st_nxt.flags[SE_POS] = 1'b1;
    end
    if (sleep_i && !asleep) begin
      st_nxt.flags[WE_POS] = 1'b1;
      st_nxt.flags[SE_POS] = 1'b0;
      st_nxt.mode = SFRC_SLEEP;
    end
    // interrupt vectoring after the instruction following sleep
    if (st_r.irq_pending && instr_done_i) begin
      st_nxt.irq_pending = 1'b0;
      st_nxt.pc_load = IRQ_VEC;
      st_nxt.pc_load_vld = 1'b1;
    end
    // resets and wakes, highest priority last
    if (evt_i.irq_wake && asleep) begin
      st_nxt.flags[WE_POS] = 1'b1;
      st_nxt.flags[SE_POS] = 1'b0;
      st_nxt.mode = SFRC_RUN;
      st_nxt.pc_load = 15'(pc_i + 15'h0001);
      st_nxt.pc_load_vld = 1'b1;
      st_nxt.irq_pending = global_irq_enable_i;
    end
    if (evt_i.wdt_timeout) begin
      st_nxt.flags[WE_POS] = 1'b0;
      if (asleep) begin
        st_nxt.flags[SE_POS] = 1'b0;
        st_nxt.mode = SFRC_RUN;
        st_nxt.pc_load = 15'(pc_i + 15'h0001);
        st_nxt.pc_load_vld = 1'b1;
      end else begin
        st_nxt.cause[WDR_POS] = 1'b0;
        st_nxt.pc_load = RESET_VEC;
        st_nxt.pc_load_vld = 1'b1;
        st_nxt.irq_pending = 1'b0;
      end
    end
    if (evt_i.sw_reset) begin
      st_nxt.cause[SW_POS] = 1'b0;
      st_nxt.pc_load = RESET_VEC;
      st_nxt.pc_load_vld = 1'b1;
      st_nxt.irq_pending = 1'b0;
    end
    if (stk_ovf_rst || stk_unf_rst) begin
      if (stk_ovf_rst) begin
        st_nxt.cause[OVF_POS] = 1'b1;
      end
      if (stk_unf_rst) begin
        st_nxt.cause[UNF_POS] = 1'b1;
      end
      st_nxt.pc_load = RESET_VEC;
      st_nxt.pc_load_vld = 1'b1;
      st_nxt.irq_pending = 1'b0;
    end
    if (evt_i.pin) begin
      st_nxt.cause[PIN_POS] = 1'b0;
      if (asleep) begin
        st_nxt.flags[WE_POS] = 1'b1;
        st_nxt.flags[SE_POS] = 1'b0;
      end
      st_nxt.mode = SFRC_RUN;
      st_nxt.pc_load = RESET_VEC;
      st_nxt.pc_load_vld = 1'b1;
      st_nxt.irq_pending = 1'b0;
    end
    if (bo_evt) begin
      st_nxt.cause[BRN_POS] = 1'b0;
      st_nxt.cause[OVF_POS] = 1'b0;
      st_nxt.cause[UNF_POS] = 1'b0;
      st_nxt.cause[PIN_POS] = 1'b1;
      st_nxt.cause[SW_POS] = 1'b1;
      st_nxt.flags = FLAGS_RST; // arithmetic bits clear as well
      st_nxt.mode = SFRC_RUN;
      st_nxt.pc_load = RESET_VEC;
      st_nxt.pc_load_vld = 1'b1;
      st_nxt.irq_pending = 1'b0;
    end
    if (evt_i.por) begin
      st_nxt.cause = CAUSE_POR;
      st_nxt.flags = FLAGS_RST;
      st_nxt.mode = SFRC_RUN;
      st_nxt.pc_load = RESET_VEC;
      st_nxt.pc_load_vld = 1'b1;
      st_nxt.irq_pending = 1'b0;
    end
    st_nxt.flags[7:5] = 3'h0;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r.flags <= FLAGS_RST;
      st_r.cause <= CAUSE_POR;
      st_r.mode <= SFRC_RUN;
      st_r.pc_load <= RESET_VEC;
      st_r.pc_load_vld <= 1'b0;
      st_r.alu_res <= 8'h00;
      st_r.irq_pending <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_o = st_r.flags;
  assign cause_o = st_r.cause;
  assign alu_res_o = st_r.alu_res;
  assign asleep_o = asleep;
  assign pc_load_o = st_r.pc_load;
  assign pc_load_vld_o = st_r.pc_load_vld;
  assign irq_push_o = st_r.pc_load_vld && (st_r.pc_load == IRQ_VEC);

  property p_top_zero;
    @(posedge mclk_i) disable iff (!rst_b_i) flags_o[7:5] == 3'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("top flag bits not zero");

  property p_wr_protect;
    @(posedge mclk_i) disable iff (!rst_b_i)
      flags_we_i && !wdt_clear_i && !sleep_i && evt_i == '0 && !bo_lvl |=>
        flags_o[WE_POS] == $past(flags_o[WE_POS]);
  endproperty
  a_wr_protect: assert property (p_wr_protect) else $error("expiry bit changed by write");

  property p_op_wins;
    @(posedge mclk_i) disable iff (!rst_b_i)
      flags_we_i && z_upd && !evt_i.por && !bo_evt |=> flags_o[Z_POS] == $past(af.z);
  endproperty
  a_op_wins: assert property (p_op_wins) else $error("written zero bit kept");

  property p_add_carry;
    @(posedge mclk_i) disable iff (!rst_b_i)
      alu_i.op == SFRC_OP_ADD && !evt_i.por && !bo_evt |=> flags_o[C_POS] == $past(add_cy);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_zero;
    @(posedge mclk_i) disable iff (!rst_b_i)
      alu_i.op == SFRC_OP_LOGIC && !evt_i.por && !bo_evt |=> flags_o[Z_POS] == (alu_res_o == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero bit wrong");

  property p_sleep;
    @(posedge mclk_i) disable iff (!rst_b_i)
      sleep_i && !asleep && !wdt_clear_i && evt_i == '0 && !bo_lvl |=>
        !flags_o[SE_POS] && flags_o[WE_POS] && asleep_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry flags wrong");

  property p_por;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i.por |=> cause_o == CAUSE_POR && flags_o[WE_POS] && pc_load_vld_o && pc_load_o == RESET_VEC;
  endproperty
  a_por: assert property (p_por) else $error("power-on state wrong");

  property p_wdt_wake;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h20 && asleep && !bo_lvl |=>
        !flags_o[WE_POS] && !flags_o[SE_POS] && pc_load_o == 15'($past(pc_i) + 15'h0001);
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_pin_run;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h10 && !asleep && !bo_lvl && !flags_we_i && !cause_we_i |=>
        !cause_o[PIN_POS] && cause_o[7:4] == $past(cause_o[7:4]);
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("pin reset cause wrong");

  property p_wr_block;
    @(posedge mclk_i) disable iff (!rst_b_i)
      flags_we_i && z_upd && !c_upd && !nov_upd && !evt_i.por && !bo_evt |=>
        flags_o[C_POS] == $past(flags_o[C_POS]) && flags_o[NOV_POS] == $past(flags_o[NOV_POS]);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("written carry bits kept");

  property p_wdt_clear;
    @(posedge mclk_i) disable iff (!rst_b_i)
      wdt_clear_i && !sleep_i && evt_i == '0 && !bo_evt |=> flags_o[WE_POS] && flags_o[SE_POS];
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear flags wrong");

  property p_wdt_rst;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h20 && !asleep && !bo_evt && !cause_we_i |=>
        !flags_o[WE_POS] && !cause_o[WDR_POS] && pc_load_vld_o && pc_load_o == RESET_VEC;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset wrong");

  property p_stk;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h04 && stack_fault_reset_enable_i && !bo_evt && !cause_we_i |=>
        cause_o[OVF_POS] && pc_load_vld_o && pc_load_o == RESET_VEC;
  endproperty
  a_stk: assert property (p_stk) else $error("stack overflow reset wrong");

  property p_stk_off;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h04 && !stack_fault_reset_enable_i && !instr_done_i && !bo_evt && !cause_we_i |=>
        !pc_load_vld_o && cause_o == $past(cause_o);
  endproperty
  a_stk_off: assert property (p_stk_off) else $error("disabled stack fault acted");

  property p_pin_sleep;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h10 && asleep && !bo_evt |=>
        flags_o[WE_POS] && !flags_o[SE_POS] && !cause_o[PIN_POS] && !asleep_o;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("pin reset in sleep wrong");

  property p_irq_wake;
    @(posedge mclk_i) disable iff (!rst_b_i)
      evt_i == 8'h01 && asleep && !bo_evt && !cause_we_i |=>
        flags_o[WE_POS] && !flags_o[SE_POS] && cause_o == $past(cause_o) && pc_load_o == 15'($past(pc_i) + 15'h0001);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake wrong");

  property p_irq_vec;
    @(posedge mclk_i) disable iff (!rst_b_i)
      st_r.irq_pending && instr_done_i && evt_i == '0 && !bo_evt |=> irq_push_o && pc_load_o == IRQ_VEC;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector missing");

  property p_bo;
    @(posedge mclk_i) disable iff (!rst_b_i)
      bo_evt && !evt_i.por |=>
        flags_o == FLAGS_RST && !cause_o[BRN_POS] && !cause_o[OVF_POS] && !cause_o[UNF_POS]
        && cause_o[PIN_POS] && cause_o[SW_POS] && pc_load_vld_o;
  endproperty
  a_bo: assert property (p_bo) else $error("brown-out state wrong");

  property p_sub_borrow;
    @(posedge mclk_i) disable iff (!rst_b_i)
      alu_i.op == SFRC_OP_SUB && !evt_i.por && !bo_evt |=> flags_o[C_POS] == $past(sub_nb);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong");

  c_sleep: cover property (@(posedge mclk_i) disable iff (!rst_b_i) sleep_i ##1 asleep);
  c_irq: cover property (@(posedge mclk_i) disable iff (!rst_b_i) irq_push_o);
  c_stk: cover property (@(posedge mclk_i) disable iff (!rst_b_i) stk_ovf_rst);
endmodule

// *** sfrc_pkg.sv ***
// package for status-flag and reset-cause block
// assumes one core clock, all inputs synchronous except the brown-out level
package sfrc_pkg;
  localparam int FLAG_W = 8;
  localparam int C_POS = 0;
  localparam int NOV_POS = 1;
  localparam int Z_POS = 2;
  localparam int SE_POS = 3;
  localparam int WE_POS = 4;
  localparam logic [7:0] FLAGS_RST = 8'h18;
  localparam logic [7:0] FLAGS_WMASK = 8'h07;
  // cause register bit positions
  localparam int BRN_POS = 0;
  localparam int POR_POS = 1;
  localparam int SW_POS = 2;
  localparam int PIN_POS = 3;
  localparam int WDR_POS = 4;
  localparam int UNF_POS = 6;
  localparam int OVF_POS = 7;
  localparam logic [7:0] CAUSE_POR = 8'h1C;
  localparam logic [7:0] CAUSE_MASK = 8'hDF;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] IRQ_VEC = 15'h0004;
  localparam logic [3:0] NIB_MSB = 4'h3;

  typedef enum logic [2:0] {
    SFRC_OP_NONE, SFRC_OP_ADD, SFRC_OP_SUB, SFRC_OP_LOGIC, SFRC_OP_RRF, SFRC_OP_RLF
  } sfrc_op_e;

  typedef struct packed {
    sfrc_op_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] src;
  } sfrc_alu_s;

  typedef struct packed {
    logic por;
    logic brownout;
    logic wdt_timeout;
    logic pin;
    logic sw_reset;
    logic stk_ovf;
    logic stk_unf;
    logic irq_wake;
  } sfrc_evt_s;

  typedef struct packed {
    logic c;
    logic nov;
    logic z;
  } sfrc_aflag_s;

  typedef enum logic [1:0] {SFRC_RUN, SFRC_SLEEP} sfrc_mode_e;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] cause;
    sfrc_mode_e mode;
    logic [14:0] pc_load;
    logic pc_load_vld;
    logic [7:0] alu_res;
    logic irq_pending;
  } sfrc_state_s;
endpackage

// *** sfrc_alu_flags.sv ***
// arithmetic flag generation for one alu operation
// assumes operands valid in the same cycle
module sfrc_alu_flags (
  // operation
  input wire sfrc_pkg::sfrc_alu_s alu_i,
  input wire logic carry_in_i,
  // results
  output logic [7:0] res_o,
  output sfrc_pkg::sfrc_aflag_s flag_o,
  output logic z_upd_o,
  output logic c_upd_o,
  output logic nov_upd_o
);
  import sfrc_pkg::*;
  logic [8:0] sum;
  logic [4:0] nsum;
  logic [7:0] bop;
  always_comb begin
    // subtraction adds the two's complement of b
    bop = (alu_i.op == SFRC_OP_SUB) ? 8'(~alu_i.b) : alu_i.b;
    sum = 9'({1'b0, alu_i.a}) + 9'({1'b0, bop}) + 9'((alu_i.op == SFRC_OP_SUB) ? 1 : 0);
    nsum = 5'({1'b0, alu_i.a[3:0]}) + 5'({1'b0, bop[3:0]}) + 5'((alu_i.op == SFRC_OP_SUB) ? 1 : 0);
    res_o = 8'h00;
    flag_o = '0;
    z_upd_o = 1'b0;
    c_upd_o = 1'b0;
    nov_upd_o = 1'b0;
    case (alu_i.op)
      SFRC_OP_ADD, SFRC_OP_SUB: begin
        res_o = sum[7:0];
        flag_o.c = sum[8];
        flag_o.nov = nsum[NIB_MSB + 1];
        z_upd_o = 1'b1;
        c_upd_o = 1'b1;
        nov_upd_o = 1'b1;
      end
      SFRC_OP_LOGIC: begin
        res_o = alu_i.a;
        z_upd_o = 1'b1;
      end
      SFRC_OP_RRF: begin
        res_o = {carry_in_i, alu_i.src[7:1]};
        flag_o.c = alu_i.src[0];
        c_upd_o = 1'b1;
      end
      SFRC_OP_RLF: begin
        res_o = {alu_i.src[6:0], carry_in_i};
        flag_o.c = alu_i.src[7];
        c_upd_o = 1'b1;
      end
      default: begin
        res_o = 8'h00;
      end
    endcase
    flag_o.z = (res_o == 8'h00);
  end
endmodule

// *** sfrc_sync.sv ***
// two-stage level synchroniser for the brown-out detector level
// assumes input from an analog comparator
module sfrc_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // level
  input wire logic d_i,
  output logic q_o
);
  logic [1:0] sync_r;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_r <= 2'b00;
    end else begin
      sync_r <= {sync_r[0], d_i};
    end
  end
  assign q_o = sync_r[1];
endmodule

// *** sfrc_exec_model.sv ***
// execute-stage and reset-source model facing sfrc_top
// assumes the bench calls its tasks; pulses last one cycle
module sfrc_exec_model (
  // clock
  input wire logic mclk_i,
  // execute stage
  output sfrc_pkg::sfrc_alu_s alu_o,
  output logic fwe_o,
  output logic cwe_o,
  output logic [7:0] wd_o,
  output logic [2:0] ctl_o,
  output logic [14:0] pc_o,
  output logic gie_o,
  output logic stv_o,
  // reset sources
  output sfrc_pkg::sfrc_evt_s evt_o,
  output logic bo_o
);
  import sfrc_pkg::*;
  initial begin
    alu_o = '0;
    {fwe_o, cwe_o, ctl_o, pc_o, gie_o, stv_o, bo_o} = '0;
    wd_o = 8'h00;
    evt_o = '0;
  end
  // one-cycle request; released data shows inverse
  task automatic drive(input sfrc_alu_s a, input logic [1:0] we, input logic [7:0] d,
                       input logic [2:0] c, input logic [7:0] e);
    @(posedge mclk_i);
    alu_o <= a;
    {fwe_o, cwe_o} <= we;
    wd_o <= d;
    ctl_o <= c;
    evt_o <= sfrc_evt_s'(e);
    @(posedge mclk_i);
    alu_o <= '{op: SFRC_OP_NONE, a: ~a.a, b: ~a.b, src: ~a.src};
    {fwe_o, cwe_o} <= 2'b00;
    wd_o <= ~d;
    ctl_o <= 3'b000;
    evt_o <= '0;
  endtask
  task automatic lvl(input logic [14:0] pc, input logic g, input logic s, input logic b);
    @(posedge mclk_i);
    pc_o <= pc;
    gie_o <= g;
    stv_o <= s;
    bo_o <= b;
  endtask
endmodule

// *** sfrc_tb_top.sv ***
// self-checking bench for sfrc_top
// assumes sfrc_exec_model as the execute stage
module sfrc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sfrc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  sfrc_alu_s alu;
  sfrc_evt_s evt;
  logic fwe, cwe, global_irq_enable, stv, bo, asleep, vld, push;
  logic [7:0] wd, flags, cause, res;
  logic [2:0] ctl;
  logic [14:0] pc, pcl;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  sfrc_exec_model i_sfrc_exec_model (.mclk_i(mclk_i), .alu_o(alu), .fwe_o(fwe), .cwe_o(cwe),
    .wd_o(wd), .ctl_o(ctl), .pc_o(pc), .gie_o(global_irq_enable), .stv_o(stv), .evt_o(evt), .bo_o(bo));
  sfrc_top i_sfrc_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .alu_i(alu), .flags_we_i(fwe),
    .flags_wdata_i(wd), .cause_we_i(cwe), .cause_wdata_i(wd), .wdt_clear_i(ctl[2]),
    .sleep_i(ctl[1]), .pc_i(pc), .instr_done_i(ctl[0]), .global_irq_enable_i(global_irq_enable),
    .stack_fault_reset_enable_i(stv), .evt_i(evt), .brownout_lvl_i(bo), .flags_o(flags),
    .cause_o(cause), .alu_res_o(res), .asleep_o(asleep), .pc_load_o(pcl),
    .pc_load_vld_o(vld), .irq_push_o(push));

  initial forever #25 mclk_i = ~mclk_i;

  task automatic summarize;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // jump pulse with its target
  task automatic chkj(input logic [14:0] e);
    checked++;
    if ({vld, pcl} !== {1'b1, e}) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, {vld, pcl}, {1'b1, e});
    end
  endtask
  task automatic ev(input logic [7:0] e);
    i_sfrc_exec_model.drive('0, 2'b00, 8'h00, 3'b000, e);
    @(negedge mclk_i);
  endtask
  task automatic ct(input logic [2:0] c);
    i_sfrc_exec_model.drive('0, 2'b00, 8'h00, c, 8'h00);
    @(negedge mclk_i);
  endtask
  task automatic op(input sfrc_op_e o, input logic [7:0] a, input logic [7:0] b,
                    input logic w, input logic [7:0] d);
    i_sfrc_exec_model.drive('{o, a, b, a}, {w, 1'b0}, d, 3'b000, 8'h00);
    @(negedge mclk_i);
  endtask
  task automatic cw(input logic [7:0] d);
    i_sfrc_exec_model.drive('0, 2'b01, d, 3'b000, 8'h00);
    @(negedge mclk_i);
    chk(cause, d & 8'hDF);
  endtask

  task automatic t_alu;
    logic [18:0] v [7] = '{{3'd1, 8'hFF, 8'h01}, {3'd1, 8'h08, 8'h08}, {3'd1, 8'h00, 8'h00},
      {3'd2, 8'h05, 8'h03}, {3'd2, 8'h03, 8'h05}, {3'd2, 8'h10, 8'h00}, {3'd2, 8'h20, 8'h01}};
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] n;
    foreach (v[i]) begin
      bb = (v[i][18:16] == 3'd2) ? ~v[i][7:0] : v[i][7:0];
      s = v[i][15:8] + bb + (v[i][18:16] == 3'd2);
      n = v[i][11:8] + bb[3:0] + (v[i][18:16] == 3'd2);
      op(sfrc_op_e'(v[i][18:16]), v[i][15:8], v[i][7:0], 1'b0, 8'h00);
      chk(res, s[7:0]);
      chk(flags, {5'b00011, s[7:0] == 8'h00, n[4], s[8]});
    end
    op(SFRC_OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(flags, 8'h1D);
  endtask
  task automatic t_rot;
    op(SFRC_OP_RRF, 8'h01, 8'h00, 1'b0, 8'h00);
    chk({flags[0], res}, 9'h180);
    op(SFRC_OP_RLF, 8'h7F, 8'h00, 1'b0, 8'h00);
    chk({flags[0], res}, 9'h0FF);
    op(SFRC_OP_RLF, 8'h80, 8'h00, 1'b0, 8'h00);
    chk({flags[0], res}, 9'h100);
  endtask
  task automatic t_wr;
    op(SFRC_OP_NONE, 8'h00, 8'h00, 1'b1, 8'hFF);
    chk(flags, 8'h1F);
    op(SFRC_OP_NONE, 8'h00, 8'h00, 1'b1, 8'h00);
    chk(flags, 8'h18);
    op(SFRC_OP_ADD, 8'h01, 8'h01, 1'b1, 8'h07);
    chk(flags, 8'h18);
    op(SFRC_OP_LOGIC, 8'h00, 8'h00, 1'b1, 8'h07);
    chk(flags, 8'h1C);
    op(SFRC_OP_SUB, 8'h05, 8'h03, 1'b1, 8'h00);
    chk(flags, 8'h1B);
  endtask
  task automatic t_sleep;
    ct(3'b010);
    chk(flags, 8'h13);
    chk({7'h0, asleep}, 8'h01);
    ev(8'h01);
    chkj(15'h0124);
    chk({flags, cause}, 16'h131C);
    ct(3'b100);
    chk(flags, 8'h1B);
    ct(3'b010);
    ev(8'h20);
    chkj(15'h0124);
    chk(flags, 8'h03);
    ev(8'h20);
    chkj(15'h0000);
    chk(cause, 8'h0C);
    ct(3'b100);
  endtask
  task automatic t_gie;
    i_sfrc_exec_model.lvl(15'h0123, 1'b1, 1'b1, 1'b0);
    ct(3'b010);
    ev(8'h01);
    chkj(15'h0124);
    ct(3'b001);
    chkj(15'h0004);
    chk({7'h0, push}, 8'h01);
  endtask
  task automatic t_cause;
    cw(8'hFF);
    ev(8'h10);
    chkj(15'h0000);
    chk({flags, cause}, 16'h13D7);
    ev(8'h08);
    chk(cause, 8'hD3);
    cw(8'h00);
    ev(8'h04);
    chkj(15'h0000);
    ev(8'h02);
    chk(cause, 8'hC0);
    cw(8'hFF);
    ct(3'b010);
    ev(8'h10);
    chk({flags, cause}, 16'h13D7);
    chk({7'h0, asleep}, 8'h00);
    i_sfrc_exec_model.lvl(15'h0123, 1'b1, 1'b0, 1'b0);
    ev(8'h04);
    chk({vld, cause}, 9'h0D7);
  endtask
  task automatic t_bo;
    cw(8'hFF);
    ev(8'h40);
    chkj(15'h0000);
    chk({flags, cause}, 16'h181E);
    cw(8'hFF);
    i_sfrc_exec_model.lvl(15'h0123, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 8 && vld !== 1'b1; i++) @(negedge mclk_i);
    chkj(15'h0000);
    chk(cause, 8'h1E);
    i_sfrc_exec_model.lvl(15'h0123, 1'b1, 1'b1, 1'b0);
    ev(8'h80);
    chkj(15'h0000);
    chk({flags, cause}, 16'h181C);
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      summarize;
    end
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    i_sfrc_exec_model.lvl(15'h0123, 1'b0, 1'b1, 1'b0);
    @(negedge mclk_i);
    chk({flags, cause}, 16'h181C);
    t_alu;
    t_rot;
    t_wr;
    t_sleep;
    t_gie;
    t_cause;
    t_bo;
    summarize;
  end
endmodule
